/* File: include/otfr_pkg.sv */
// Purpose: shared constants for the output terminal function router
// Assumes: 4-bit register index, 8-bit register data
// Notes:   nine setting registers sit in one indexed store
package otfr_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CFG_N  = 9;

  // setting register offsets
  localparam logic [3:0] OFF_T11_SEL   = 4'h0;
  localparam logic [3:0] OFF_T12_SEL   = 4'h1;
  localparam logic [3:0] OFF_RLY_SEL   = 4'h2;
  localparam logic [3:0] OFF_FM_SEL    = 4'h3;
  localparam logic [3:0] OFF_AM_SEL    = 4'h4;
  localparam logic [3:0] OFF_AMI_SEL   = 4'h5;
  localparam logic [3:0] OFF_T11_POL   = 4'h6;
  localparam logic [3:0] OFF_T12_POL   = 4'h7;
  localparam logic [3:0] OFF_RLY_POL   = 4'h8;
  // interrupt and state registers
  localparam logic [3:0] OFF_IRQ_STAT  = 4'h9;
  localparam logic [3:0] OFF_IRQ_MASK  = 4'hA;
  localparam logic [3:0] OFF_OUT_STATE = 4'hB;

  // values after reset
  localparam logic [7:0] RST_T11_SEL  = 8'h01;
  localparam logic [7:0] RST_T12_SEL  = 8'h00;
  localparam logic [7:0] RST_RLY_SEL  = 8'h05;
  localparam logic [7:0] RST_MON_SEL  = 8'h00;
  localparam logic [7:0] RST_TERM_POL = 8'h00;
  localparam logic [7:0] RST_RLY_POL  = 8'h01;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // discrete function codes
  localparam logic [7:0] FN_RUN        = 8'h00;
  localparam logic [7:0] FN_SPEED_REACH = 8'h01;
  localparam logic [7:0] FN_ABOVE_THR  = 8'h02;
  localparam logic [7:0] FN_OVERCURR   = 8'h03;
  localparam logic [7:0] FN_PID_ERR    = 8'h04;
  localparam logic [7:0] FN_FAULT      = 8'h05;
  localparam logic [7:0] FN_AT_THR     = 8'h06;
  localparam logic [7:0] FN_POWER_LOSS = 8'h08;
  localparam logic [7:0] FN_LOW_SUPPLY = 8'h09;
  localparam logic [7:0] FN_RUN_HOURS  = 8'h0B;
  localparam logic [7:0] FN_ON_HOURS   = 8'h0C;
  localparam logic [7:0] FN_THERMAL    = 8'h0D;

  // polarity: 00 normally open, 01 normally closed
  localparam int POL_BIT = 0;

  // analog monitor codes
  localparam logic [7:0] MON_FREQ     = 8'h00;
  localparam logic [7:0] MON_CURRENT  = 8'h01;
  localparam logic [7:0] MON_DIG_FREQ = 8'h03;
  localparam logic [7:0] MON_VOLTAGE  = 8'h04;
  localparam logic [7:0] MON_POWER    = 8'h05;
  localparam logic [7:0] MON_THERMAL  = 8'h06;
  localparam logic [7:0] MON_RAMP     = 8'h07;

  // interrupt status bit positions
  localparam int IRQ_W    = 4;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_T11  = 1;
  localparam int IRQ_T12  = 2;
  localparam int IRQ_RLY  = 3;

  function automatic logic [7:0] cfg_reset_value(input int idx);
    case (idx)
      0: cfg_reset_value = RST_T11_SEL;
      1: cfg_reset_value = RST_T12_SEL;
      2: cfg_reset_value = RST_RLY_SEL;
      8: cfg_reset_value = RST_RLY_POL;
      default: cfg_reset_value = 8'h00;
    endcase
  endfunction

endpackage

/* File: hw/otfr_func_sel.sv */
// Purpose: one discrete output: function select plus polarity
// Assumes: flag vector indexed by function code, reserved slots zero
// Notes:   combinational; the caller registers the result
module otfr_func_sel #(
  parameter bit HAS_THERMAL = 1'b0
) (
  input  wire logic [7:0]  func_code,
  input  wire logic [15:0] func_flags,
  input  wire logic [7:0]  polarity,
  output logic             drive_level
);

  function automatic logic code_defined(input logic [7:0] c, input logic thr);
    case (c)
      otfr_pkg::FN_RUN, otfr_pkg::FN_SPEED_REACH, otfr_pkg::FN_ABOVE_THR,
      otfr_pkg::FN_OVERCURR, otfr_pkg::FN_PID_ERR, otfr_pkg::FN_FAULT,
      otfr_pkg::FN_AT_THR, otfr_pkg::FN_POWER_LOSS, otfr_pkg::FN_LOW_SUPPLY,
      otfr_pkg::FN_RUN_HOURS, otfr_pkg::FN_ON_HOURS: code_defined = 1'b1;
      otfr_pkg::FN_THERMAL: code_defined = thr;
      default: code_defined = 1'b0;
    endcase
  endfunction

  wire logic defined_code;
  wire logic func_active;

  assign defined_code = code_defined(func_code, HAS_THERMAL);
  assign func_active = defined_code ? func_flags[func_code[3:0]] : 1'b0;
  assign drive_level = func_active ^ polarity[otfr_pkg::POL_BIT];

endmodule // otfr_func_sel

/* File: hw/otfr_mon_sel.sv */
// Purpose: quantity select for one analog monitor output
// Assumes: all quantities share one width
// Notes:   unknown codes give zero rather than a stale quantity
module otfr_mon_sel #(
  parameter int MON_W      = 16,
  parameter bit DIGITAL_OK = 1'b0
) (
  input  wire logic [7:0]       mon_sel,
  input  wire logic [MON_W-1:0] q_freq,
  input  wire logic [MON_W-1:0] q_current,
  input  wire logic [MON_W-1:0] q_dig_freq,
  input  wire logic [MON_W-1:0] q_voltage,
  input  wire logic [MON_W-1:0] q_power,
  input  wire logic [MON_W-1:0] q_thermal,
  input  wire logic [MON_W-1:0] q_ramp,
  output logic [MON_W-1:0]      mon_level
);

  wire logic dig_sel;

  assign dig_sel = DIGITAL_OK && (mon_sel == otfr_pkg::MON_DIG_FREQ);
  assign mon_level =
    (mon_sel == otfr_pkg::MON_FREQ)    ? q_freq    :
    (mon_sel == otfr_pkg::MON_CURRENT) ? q_current :
    dig_sel                            ? q_dig_freq :
    (mon_sel == otfr_pkg::MON_VOLTAGE) ? q_voltage :
    (mon_sel == otfr_pkg::MON_POWER)   ? q_power   :
    (mon_sel == otfr_pkg::MON_THERMAL) ? q_thermal :
    (mon_sel == otfr_pkg::MON_RAMP)    ? q_ramp    : '0;

endmodule // otfr_mon_sel

/* File: hw/otfr_top.sv */
// Purpose: routes drive status to terminals 11, 12, alarm relay and monitors
// Assumes: all status inputs come from logic on sys_clk
// Notes:   outputs lag their cause by one clock, two for codes 02, 03, 05; equal-to-level holds state
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.

// Function
// - three outputs pick status by function code
// - reset codes 01, 00, 05
// - polarity 00 open, 01 closed inverts
// - terminals open, relay closed after reset
// - three monitor selects, default output frequency
// - code 00 follows run state
// - code 01 when frequency equals setpoint
// - code 02 sets accelerating, clears decelerating
// - code 03 overcurrent above warning level
// - code 04 PID error above threshold
// - code 05 trip latch until keypad reset
// - code 06 at accel or decel threshold
// - codes 08, 09 follow supply loss
// - code 11 run hours over limit
// - code 12 powered hours over limit
// - monitor code map, 03 frequency meter only
module otfr_top #(
  parameter int FREQ_W      = 16,
  parameter int MON_W       = 16,
  parameter bit HAS_THERMAL = 1'b0
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset,
  input  wire logic [otfr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [otfr_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [otfr_pkg::DATA_W-1:0]    reg_rdata,
  output logic                           irq,
  input  wire logic                      motor_running,
  input  wire logic                      accelerating,
  input  wire logic                      decelerating,
  input  wire logic [FREQ_W-1:0]         output_freq,
  input  wire logic [FREQ_W-1:0]         set_frequency,
  input  wire logic [FREQ_W-1:0]         accel_arrival_threshold,
  input  wire logic [FREQ_W-1:0]         decel_arrival_threshold,
  input  wire logic [FREQ_W-1:0]         output_current,
  input  wire logic [FREQ_W-1:0]         overcurrent_warn_level,
  input  wire logic                      pid_error_flag,
  input  wire logic                      trip_event,
  input  wire logic                      keypad_reset,
  input  wire logic                      power_loss_flag,
  input  wire logic                      low_supply_flag,
  input  wire logic                      run_hours_flag,
  input  wire logic                      powered_hours_flag,
  input  wire logic                      thermal_alarm_flag,
  input  wire logic [MON_W-1:0]          mon_freq,
  input  wire logic [MON_W-1:0]          mon_current,
  input  wire logic [MON_W-1:0]          mon_dig_freq,
  input  wire logic [MON_W-1:0]          mon_voltage,
  input  wire logic [MON_W-1:0]          mon_power,
  input  wire logic [MON_W-1:0]          mon_thermal,
  input  wire logic [MON_W-1:0]          mon_ramp,
  output logic                           term11_out,
  output logic                           term12_out,
  output logic                           alarm_relay_out,
  output logic [MON_W-1:0]               frequency_meter_out,
  output logic [MON_W-1:0]               second_monitor_out,
  output logic [MON_W-1:0]               current_monitor_out
);

  logic [7:0]                  cfg_r [otfr_pkg::CFG_N];
  logic                        above_thresh_r;
  logic                        overcurrent_warning_r;
  logic                        fault_latched_flag_r;
  logic [otfr_pkg::IRQ_W-1:0]  irq_stat_r;
  logic [otfr_pkg::IRQ_W-1:0]  irq_stat_nxt;
  logic [otfr_pkg::IRQ_W-1:0]  irq_mask_r;
  logic                        irq_r;
  logic [7:0]                  rdata_r;
  logic [7:0]                  rdata_nxt;
  logic                        t11_r;
  logic                        t12_r;
  logic                        rly_r;
  logic [MON_W-1:0]            fm_r;
  logic [MON_W-1:0]            am_r;
  logic [MON_W-1:0]            ami_r;

  wire logic                   speed_reached_flag;
  wire logic                   at_thresh_flag;
  wire logic                   above_thresh_nxt;
  wire logic                   overcurrent_nxt;
  wire logic                   fault_nxt;
  wire logic [15:0]            func_flags;
  wire logic                   t11_nxt;
  wire logic                   t12_nxt;
  wire logic                   rly_nxt;
  wire logic [MON_W-1:0]       fm_nxt;
  wire logic [MON_W-1:0]       am_nxt;
  wire logic [MON_W-1:0]       ami_nxt;
  wire logic                   cfg_addr_hit;
  wire logic                   rd_stat;
  wire logic                   wr_mask;
  wire logic [otfr_pkg::IRQ_W-1:0] irq_events;

  assign speed_reached_flag = (output_freq == set_frequency);
  // exact arrival at either ramp threshold
  assign at_thresh_flag = (accelerating && output_freq == accel_arrival_threshold) ||
                          (decelerating && output_freq == decel_arrival_threshold);
  // hysteresis: set on accel, cleared on decel, else held
  assign above_thresh_nxt =
    (accelerating && output_freq >= accel_arrival_threshold) ? 1'b1 :
    (decelerating && output_freq <  decel_arrival_threshold) ? 1'b0 : above_thresh_r;
  // equal to level keeps the previous answer
  assign overcurrent_nxt =
    (output_current > overcurrent_warn_level) ? 1'b1 :
    (output_current < overcurrent_warn_level) ? 1'b0 : overcurrent_warning_r;
  // a trip in the clearing cycle still latches
  assign fault_nxt = trip_event || (fault_latched_flag_r && !keypad_reset);

  // flag vector indexed by function code, gaps reserved
  assign func_flags = {2'b00,
                       thermal_alarm_flag,
                       powered_hours_flag,    // powered hours
                       run_hours_flag,        // run hours
                       1'b0,
                       low_supply_flag,       // undervoltage
                       power_loss_flag,       // supply loss
                       1'b0,
                       at_thresh_flag,
                       fault_latched_flag_r,
                       pid_error_flag,        // PID deviation
                       overcurrent_warning_r,
                       above_thresh_r,
                       speed_reached_flag,
                       motor_running};        // run state

  otfr_func_sel #(.HAS_THERMAL(HAS_THERMAL)) u_sel_t11 (
    .func_code   (cfg_r[otfr_pkg::OFF_T11_SEL]),
    .func_flags  (func_flags),
    .polarity    (cfg_r[otfr_pkg::OFF_T11_POL]),
    .drive_level (t11_nxt)
  );

  otfr_func_sel #(.HAS_THERMAL(HAS_THERMAL)) u_sel_t12 (
    .func_code   (cfg_r[otfr_pkg::OFF_T12_SEL]),
    .func_flags  (func_flags),
    .polarity    (cfg_r[otfr_pkg::OFF_T12_POL]),
    .drive_level (t12_nxt)
  );

  otfr_func_sel #(.HAS_THERMAL(HAS_THERMAL)) u_sel_rly (
    .func_code   (cfg_r[otfr_pkg::OFF_RLY_SEL]),
    .func_flags  (func_flags),
    .polarity    (cfg_r[otfr_pkg::OFF_RLY_POL]),
    .drive_level (rly_nxt)
  );

  // only the frequency meter may carry the digital frequency
  otfr_mon_sel #(.MON_W(MON_W), .DIGITAL_OK(1'b1)) u_mon_fm (
    .mon_sel    (cfg_r[otfr_pkg::OFF_FM_SEL]),
    .q_freq     (mon_freq),
    .q_current  (mon_current),
    .q_dig_freq (mon_dig_freq),
    .q_voltage  (mon_voltage),
    .q_power    (mon_power),
    .q_thermal  (mon_thermal),
    .q_ramp     (mon_ramp),
    .mon_level  (fm_nxt)
  );

  otfr_mon_sel #(.MON_W(MON_W), .DIGITAL_OK(1'b0)) u_mon_am (
    .mon_sel    (cfg_r[otfr_pkg::OFF_AM_SEL]),
    .q_freq     (mon_freq),
    .q_current  (mon_current),
    .q_dig_freq (mon_dig_freq),
    .q_voltage  (mon_voltage),
    .q_power    (mon_power),
    .q_thermal  (mon_thermal),
    .q_ramp     (mon_ramp),
    .mon_level  (am_nxt)
  );

  otfr_mon_sel #(.MON_W(MON_W), .DIGITAL_OK(1'b0)) u_mon_ami (
    .mon_sel    (cfg_r[otfr_pkg::OFF_AMI_SEL]),
    .q_freq     (mon_freq),
    .q_current  (mon_current),
    .q_dig_freq (mon_dig_freq),
    .q_voltage  (mon_voltage),
    .q_power    (mon_power),
    .q_thermal  (mon_thermal),
    .q_ramp     (mon_ramp),
    .mon_level  (ami_nxt)
  );

  // register bus decode
  assign cfg_addr_hit = (reg_addr < 4'(otfr_pkg::CFG_N));
  assign rd_stat      = reg_rd && (reg_addr == otfr_pkg::OFF_IRQ_STAT);
  assign wr_mask      = reg_wr && (reg_addr == otfr_pkg::OFF_IRQ_MASK);

  // events: a new trip, or any discrete output changing level
  assign irq_events[otfr_pkg::IRQ_TRIP] = fault_nxt && !fault_latched_flag_r;
  assign irq_events[otfr_pkg::IRQ_T11]  = t11_nxt != t11_r;
  assign irq_events[otfr_pkg::IRQ_T12]  = t12_nxt != t12_r;
  assign irq_events[otfr_pkg::IRQ_RLY]  = rly_nxt != rly_r;
  // read clears, but an event in the same cycle survives
  assign irq_stat_nxt = (rd_stat ? '0 : irq_stat_r) | irq_events;

  assign rdata_nxt =
    !reg_rd                                ? 8'h00 :
    cfg_addr_hit                           ? cfg_r[reg_addr] :
    (reg_addr == otfr_pkg::OFF_IRQ_STAT)   ? {4'h0, irq_stat_r} :
    (reg_addr == otfr_pkg::OFF_IRQ_MASK)   ? {4'h0, irq_mask_r} :
    (reg_addr == otfr_pkg::OFF_OUT_STATE)  ?
      {3'h0, above_thresh_r, fault_latched_flag_r, rly_r, t12_r, t11_r} : 8'h00;

  // indexed setting store with per-entry reset values
  always_ff @(posedge sys_clk)
  begin
    for (int i = 0; i < otfr_pkg::CFG_N; i++)
    begin
      if (reset)
        cfg_r[i] <= otfr_pkg::cfg_reset_value(i);
      else if (reg_wr && reg_addr == 4'(i))
        cfg_r[i] <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fault_latched_flag_r  <= 1'b0;
      above_thresh_r        <= 1'b0;
      overcurrent_warning_r <= 1'b0;
    end
    else
    begin
      fault_latched_flag_r  <= fault_nxt;
      above_thresh_r        <= above_thresh_nxt;
      overcurrent_warning_r <= overcurrent_nxt;
    end
  end

  // reset levels follow the default codes: relay closed, terminals open
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      t11_r <= 1'b0;
      t12_r <= 1'b0;
      rly_r <= 1'b1;
      fm_r  <= '0;
      am_r  <= '0;
      ami_r <= '0;
    end
    else
    begin
      t11_r <= t11_nxt;
      t12_r <= t12_nxt;
      rly_r <= rly_nxt;
      fm_r  <= fm_nxt;
      am_r  <= am_nxt;
      ami_r <= ami_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      irq_stat_r <= '0;
      irq_mask_r <= otfr_pkg::RST_IRQ_MASK;
      irq_r      <= 1'b0;
      rdata_r    <= 8'h00;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_mask)
        irq_mask_r <= reg_wdata[otfr_pkg::IRQ_W-1:0];
      irq_r      <= |(irq_stat_nxt & (wr_mask ? reg_wdata[otfr_pkg::IRQ_W-1:0] : irq_mask_r));
      rdata_r    <= rdata_nxt;
    end
  end

  assign term11_out          = t11_r;
  assign term12_out          = t12_r;
  assign alarm_relay_out     = rly_r;
  assign frequency_meter_out = fm_r;
  assign second_monitor_out  = am_r;
  assign current_monitor_out = ami_r;
  assign reg_rdata           = rdata_r;
  assign irq                 = irq_r;

  default clocking cb @(posedge sys_clk);
  endclocking

  property p_sel_defaults;
    reset |=> (cfg_r[otfr_pkg::OFF_T11_SEL] == 8'h01 && cfg_r[otfr_pkg::OFF_T12_SEL] == 8'h00
               && cfg_r[otfr_pkg::OFF_RLY_SEL] == 8'h05);
  endproperty
  a_sel_defaults: assert property (p_sel_defaults) else $error("bad select reset");

  property p_pol_defaults;
    reset |=> (cfg_r[otfr_pkg::OFF_T11_POL] == 8'h00 && cfg_r[otfr_pkg::OFF_T12_POL] == 8'h00
               && cfg_r[otfr_pkg::OFF_RLY_POL] == 8'h01);
  endproperty
  a_pol_defaults: assert property (p_pol_defaults) else $error("bad polarity reset");

  property p_mon_defaults;
    reset |=> (cfg_r[otfr_pkg::OFF_FM_SEL] == 8'h00 && cfg_r[otfr_pkg::OFF_AM_SEL] == 8'h00
               && cfg_r[otfr_pkg::OFF_AMI_SEL] == 8'h00);
  endproperty
  a_mon_defaults: assert property (p_mon_defaults) else $error("bad monitor reset");

  sequence s_t12_run_normal;
    cfg_r[otfr_pkg::OFF_T12_SEL] == 8'h00 && !cfg_r[otfr_pkg::OFF_T12_POL][0];
  endsequence
  property p_run_follow;
    disable iff (reset) s_t12_run_normal |=> (term12_out == $past(motor_running));
  endproperty
  a_run_follow: assert property (p_run_follow) else $error("run not routed");

  property p_pol_invert;
    disable iff (reset)
    (cfg_r[otfr_pkg::OFF_T11_SEL] == 8'h01 && cfg_r[otfr_pkg::OFF_T11_POL][0]
     && output_freq == set_frequency) |=> !term11_out;
  endproperty
  a_pol_invert: assert property (p_pol_invert) else $error("closed polarity not inverted");

  property p_speed_reach;
    disable iff (reset)
    (cfg_r[otfr_pkg::OFF_T11_SEL] == 8'h01 && !cfg_r[otfr_pkg::OFF_T11_POL][0])
    |=> (term11_out == $past(output_freq == set_frequency));
  endproperty
  a_speed_reach: assert property (p_speed_reach) else $error("arrival wrong");

  property p_above_hyst;
    disable iff (reset)
    (decelerating && !accelerating && output_freq >= decel_arrival_threshold)
    |=> (above_thresh_r == $past(above_thresh_r));
  endproperty
  a_above_hyst: assert property (p_above_hyst) else $error("threshold flag moved");

  sequence s_trip_held;
    fault_latched_flag_r && !keypad_reset;
  endsequence
  property p_trip_hold;
    disable iff (reset) s_trip_held |=> fault_latched_flag_r;
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip latch dropped");

  property p_reserved;
    disable iff (reset)
    (cfg_r[otfr_pkg::OFF_T12_SEL] inside {8'h07, 8'h0E} && !cfg_r[otfr_pkg::OFF_T12_POL][0])
    [*2] |-> !term12_out;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code drives");

  property p_dig_only_fm;
    disable iff (reset)
    (cfg_r[otfr_pkg::OFF_AM_SEL] == 8'h03) |=> (second_monitor_out == '0);
  endproperty
  a_dig_only_fm: assert property (p_dig_only_fm) else $error("digital freq on wrong out");

endmodule // otfr_top

/* File: verification/otfr_load_model.sv */
// Purpose: external equipment wired to the two terminals and the alarm relay
// Assumes: contacts follow their coil with no bounce
// Notes:   contact order is alarm, terminal 12, terminal 11
module otfr_load_model (
  input  wire logic       coil11,
  input  wire logic       coil12,
  input  wire logic       coil_alarm,
  output logic [2:0]      contacts
);
  timeunit 1ns;
  timeprecision 1ns;
  // no contact delay modelled: a slow relay would only hide late drive
  assign contacts = {coil_alarm, coil12, coil11};
endmodule // otfr_load_model

/* File: verification/otfr_tb_top.sv */
// Purpose: self-checking bench for the output terminal function router
// Assumes: default parameters, thermal function absent
// Notes:   read data checked by a queue watcher, outputs checked in place
module output_terminal_function_router_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, reset, reg_wr, reg_rd, irq, rd_seen;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic        motor_running, accelerating, decelerating, pid_error_flag, trip_event;
  logic        keypad_reset, power_loss_flag, low_supply_flag, run_hours_flag;
  logic        powered_hours_flag, thermal_alarm_flag, term11_out, term12_out, alarm_relay_out;
  logic [15:0] output_freq, set_frequency, accel_arrival_threshold, decel_arrival_threshold;
  logic [15:0] output_current, overcurrent_warn_level, e;
  logic [15:0] frequency_meter_out, second_monitor_out, current_monitor_out;
  logic [15:0] mq [7];
  logic [15:0] rv [4];
  logic [15:0] exp_q [$];
  logic [23:0] p;
  logic [2:0]  contacts;
  logic [7:0]  rst_tab [9] = '{8'h01, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  int          bad_count, tests_run;

  otfr_top dut (
    .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .motor_running, .accelerating, .decelerating, .output_freq, .set_frequency,
    .accel_arrival_threshold, .decel_arrival_threshold, .output_current,
    .overcurrent_warn_level, .pid_error_flag, .trip_event, .keypad_reset,
    .power_loss_flag, .low_supply_flag, .run_hours_flag, .powered_hours_flag,
    .thermal_alarm_flag, .mon_freq(mq[0]), .mon_current(mq[1]), .mon_dig_freq(mq[2]),
    .mon_voltage(mq[3]), .mon_power(mq[4]), .mon_thermal(mq[5]), .mon_ramp(mq[6]),
    .term11_out, .term12_out, .alarm_relay_out, .frequency_meter_out,
    .second_monitor_out, .current_monitor_out
  );

  otfr_load_model load (
    .coil11(term11_out), .coil12(term12_out), .coil_alarm(alarm_relay_out), .contacts
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // strobes stay up for a following transfer; settle or the caller drops them
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] care, input logic [7:0] v);
    exp_q.push_back({care, v});
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask

  // outputs lag their cause by one edge after the cause is sampled
  task automatic settle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  function automatic logic fexp(input int c);
    case (c)
      0: fexp = motor_running;
      1: fexp = output_freq == set_frequency;
      3: fexp = output_current > overcurrent_warn_level;
      4: fexp = pid_error_flag;
      6: fexp = (accelerating && output_freq == accel_arrival_threshold)
             || (decelerating && output_freq == decel_arrival_threshold);
      8: fexp = power_loss_flag;
      9: fexp = low_supply_flag;
      11: fexp = run_hours_flag;
      12: fexp = powered_hours_flag;
      default: fexp = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] mexp(input int c, input logic fm);
    if (c == 2 || (c == 3 && !fm))
      return 16'h0000;
    return (c < 2) ? mq[c] : mq[c - 1];
  endfunction

  always @(posedge sys_clk)
    rd_seen <= reg_rd;

  // read data stands only in the cycle after the strobe, so look mid-cycle
  always @(negedge sys_clk)
    if (rd_seen === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk({8'h00, reg_rdata & e[15:8]}, {8'h00, e[7:0] & e[15:8]});
    end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end

  initial
  begin
    void'($urandom(32'h54A16B06));
    reset = 1'b1;
    {reg_wr, reg_rd, motor_running, accelerating, decelerating, pid_error_flag} = 6'h00;
    {trip_event, keypad_reset, power_loss_flag, low_supply_flag} = 4'h0;
    {run_hours_flag, powered_hours_flag, thermal_alarm_flag} = 3'h0;
    {output_freq, accel_arrival_threshold, decel_arrival_threshold} = 48'h0;
    {output_current, overcurrent_warn_level, reg_addr, reg_wdata} = 44'h0;
    set_frequency = 16'h0001;
    foreach (mq[i]) mq[i] = 16'h0000;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    settle();
    chk({term11_out, term12_out, alarm_relay_out, contacts}, 16'h000C);
    @(posedge sys_clk);
    wr(4'hC, 8'h5A);
    for (int i = 0; i < 9; i++)
      rd(4'(i), 8'hFF, rst_tab[i]);
    rd(otfr_pkg::OFF_IRQ_MASK, 8'hFF, 8'h00);
    rd(4'hC, 8'hFF, 8'h00);
    // code 02 holds state, so it gets its own sequence below
    for (int c = 0; c < 16; c++)
      repeat ((c == 2) ? 0 : 3)
      begin
        foreach (rv[i]) rv[i] = 16'($urandom);
        p = 24'($urandom);
        set_frequency <= rv[0];
        accel_arrival_threshold <= rv[1];
        decel_arrival_threshold <= rv[2];
        output_freq <= rv[$urandom_range(3)];
        output_current <= rv[3];
        overcurrent_warn_level <= rv[3] ^ 16'h0001;
        {accelerating, decelerating} <= 2'(1 << $urandom_range(2));
        {pid_error_flag, power_loss_flag, low_supply_flag, run_hours_flag} <= 4'($urandom);
        {powered_hours_flag, thermal_alarm_flag, motor_running} <= 3'($urandom);
        wr(otfr_pkg::OFF_T11_SEL, 8'(c));
        wr(otfr_pkg::OFF_T12_SEL, 8'(c));
        wr(otfr_pkg::OFF_RLY_SEL, 8'(c));
        wr(otfr_pkg::OFF_T11_POL, p[7:0]);
        wr(otfr_pkg::OFF_T12_POL, p[15:8]);
        wr(otfr_pkg::OFF_RLY_POL, p[23:16]);
        rd(otfr_pkg::OFF_T11_POL, 8'hFF, p[7:0]);
        settle();
        chk({15'h0000, term11_out}, {15'h0000, fexp(c) ^ p[0]});
        chk({15'h0000, term12_out}, {15'h0000, fexp(c) ^ p[8]});
        chk({13'h0000, contacts}, {13'h0000, {3{fexp(c)}} ^ {p[16], p[8], p[0]}});
        @(posedge sys_clk);
      end
    for (int c = 0; c < 8; c++)
    begin
      foreach (mq[i]) mq[i] <= 16'($urandom);
      wr(otfr_pkg::OFF_FM_SEL, 8'(c));
      wr(otfr_pkg::OFF_AM_SEL, 8'(c));
      wr(otfr_pkg::OFF_AMI_SEL, 8'(c));
      settle();
      chk(frequency_meter_out, mexp(c, 1'b1));
      chk(second_monitor_out, mexp(c, 1'b0));
      chk(current_monitor_out, mexp(c, 1'b0));
      @(posedge sys_clk);
    end
    {accelerating, output_freq, accel_arrival_threshold} <= {1'b1, 16'h0064, 16'h0064};
    decel_arrival_threshold <= 16'h0032;
    wr(otfr_pkg::OFF_T11_SEL, otfr_pkg::FN_ABOVE_THR);
    wr(otfr_pkg::OFF_T11_POL, 8'h00);
    settle();
    chk({15'h0000, term11_out}, 16'h0001);
    @(posedge sys_clk);
    {accelerating, output_freq} <= {1'b0, 16'h003C};
    settle();
    chk({15'h0000, term11_out}, 16'h0001);
    @(posedge sys_clk);
    {decelerating, output_freq} <= {1'b1, 16'h0028};
    settle();
    chk({15'h0000, term11_out}, 16'h0000);
    @(posedge sys_clk);
    wr(otfr_pkg::OFF_T11_SEL, 8'h0E);
    wr(otfr_pkg::OFF_T12_SEL, 8'h0E);
    wr(otfr_pkg::OFF_RLY_SEL, otfr_pkg::FN_FAULT);
    wr(otfr_pkg::OFF_RLY_POL, 8'h01);
    wr(otfr_pkg::OFF_IRQ_MASK, 8'h01);
    settle();
    @(posedge sys_clk);
    rd(otfr_pkg::OFF_IRQ_STAT, 8'hF1, 8'h00);
    settle();
    chk({14'h0000, irq, alarm_relay_out}, 16'h0001);
    @(posedge sys_clk);
    trip_event <= 1'b1;
    @(posedge sys_clk);
    trip_event <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk({13'h0000, irq, alarm_relay_out, contacts[2]}, 16'h0004);
    @(posedge sys_clk);
    rd(otfr_pkg::OFF_IRQ_STAT, 8'hFF, 8'h09);
    reg_rd <= 1'b0;
    keypad_reset <= 1'b1;
    @(posedge sys_clk);
    keypad_reset <= 1'b0;
    settle();
    chk({14'h0000, irq, alarm_relay_out}, 16'h0001);
    end_sim();
  end
endmodule // output_terminal_function_router_tb_top
